// ==== hw/xag_pkg.sv ====
package xag_pkg;
    localparam int XagAddrW = 16;
    localparam int XagByteW = 8;
    localparam int XagRamBytes = 1024;
    localparam int XagRamAw = 10;
    localparam logic [7:0] XagPageReset = 8'h00;
    localparam logic [7:0] XagPointerReset = 8'h00;
    localparam logic [15:0] XagRamBase = 16'h0000;
    typedef enum logic [1:0] {
        XAG_IDLE = 2'b00,
        XAG_RAM = 2'b01,
        XAG_OFFCHIP = 2'b11,
        XAG_FLASH = 2'b10
    } xag_state_t;
endpackage : xag_pkg

// ==== hw/xag_mem_if.sv ====
`timescale 1ns/100ps
interface xag_mem_if;
    logic we;
    logic re;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output re, output addr, output wdata, input rdata);
    modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface : xag_mem_if

// ==== hw/xag_ram.sv ====
`timescale 1ns/100ps
module xag_ram import xag_pkg::*; #(
    parameter int Depth = XagRamBytes
) (
    input wire logic clk_sys,
    xag_mem_if.mem port
);
    logic [7:0] mem [Depth];
    logic [7:0] rdata_q;
    always_ff @(posedge clk_sys) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        if (port.re) begin
            rdata_q <= mem[port.addr];
        end
    end
    assign port.rdata = rdata_q;
endmodule : xag_ram

// ==== hw/external_data_space_address_generation.sv ====
// Function
// - 1k on-chip RAM mapped in external space.
// - Wide form uses whole data pointer address.
// - Data pointer visible as high/low bytes.
// - Narrow form: page high, index low.
// - External space by default; flash for writes when enabled.
// - Off-chip accesses go to memory interface.
`timescale 1ns/100ps
module external_data_space_address_generation import xag_pkg::*; #(
    parameter bit HasOffchip = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic dataPointerHighWe,
    input wire logic dataPointerLowWe,
    input wire logic pageWe,
    input wire logic [7:0] cpuWdata,
    input wire logic xmoveReq,
    input wire logic xmoveWrite,
    input wire logic xmoveWide,
    input wire logic [7:0] indexValue,
    input wire logic [7:0] xmoveWdata,
    input wire logic flashWriteEn,
    input wire logic offchipRamOnly,
    output logic [7:0] dataPointerHigh,
    output logic [7:0] dataPointerLow,
    output logic [7:0] xramPageSelect,
    output logic xmoveDone,
    output logic [7:0] xmoveRdata,
    output logic offchipReq,
    output logic offchipWrite,
    output logic [15:0] offchipAddr,
    output logic [7:0] offchipWdata,
    input wire logic offchipDone,
    input wire logic [7:0] offchipRdata,
    output logic flashWriteReq,
    output logic [15:0] flashAddr,
    output logic [7:0] flashWdata
);
    logic [7:0] ptrHigh_q, ptrHigh_d, ptrLow_q, ptrLow_d, page_q, page_d;
    xag_state_t state_q, state_d;
    logic [15:0] addr_q, addr_d, effAddr;
    logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic write_q, write_d, done_q, done_d;
    logic offReq_q, offReq_d, flReq_q, flReq_d;
    logic inRam;
    xag_mem_if memPort ();

    xag_ram u_ram (
        .clk_sys(clk_sys),
        .port(memPort.mem)
    );

    always_comb begin
        ptrHigh_d = dataPointerHighWe ? cpuWdata : ptrHigh_q;
        ptrLow_d = dataPointerLowWe ? cpuWdata : ptrLow_q;
        page_d = pageWe ? cpuWdata : page_q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ptrHigh_q <= XagPointerReset;
            ptrLow_q <= XagPointerReset;
            page_q <= XagPageReset;
        end else begin
            ptrHigh_q <= ptrHigh_d;
            ptrLow_q <= ptrLow_d;
            page_q <= page_d;
        end
    end

    // Address is formed from the register values as they stand when the access starts.
    assign effAddr = xmoveWide ? {ptrHigh_q, ptrLow_q} : {page_q, indexValue};
    // The RAM window wins over off-chip, but not over an enabled flash write, when the off-chip interface is absent or not forced.
    assign inRam = (effAddr < XagRamBase + 16'(XagRamBytes)) && !offchipRamOnly;

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        write_d = write_q;
        rdata_d = rdata_q;
        done_d = 1'b0;
        offReq_d = 1'b0;
        flReq_d = 1'b0;
        memPort.we = 1'b0;
        memPort.re = 1'b0;
        memPort.addr = addr_q[9:0];
        memPort.wdata = wdata_q;
        case (state_q)
            XAG_IDLE: begin
                if (xmoveReq) begin
                    addr_d = effAddr;
                    wdata_d = xmoveWdata;
                    write_d = xmoveWrite;
                    if (xmoveWrite && flashWriteEn) begin
                        state_d = XAG_FLASH;
                        flReq_d = 1'b1;
                    end else if (inRam || !HasOffchip) begin
                        state_d = XAG_RAM;
                        // Reading here fills the memory's output register one edge early,
                        // so the read byte can still leave the block from a flip-flop.
                        memPort.re = !xmoveWrite;
                        memPort.addr = effAddr[9:0];
                    end else begin
                        state_d = XAG_OFFCHIP;
                        offReq_d = 1'b1;
                    end
                end
            end
            XAG_RAM: begin
                memPort.we = write_q;
                if (!write_q) begin
                    rdata_d = memPort.rdata;
                end
                done_d = 1'b1;
                state_d = XAG_IDLE;
            end
            XAG_OFFCHIP: begin
                if (offchipDone) begin
                    rdata_d = offchipRdata;
                    done_d = 1'b1;
                    state_d = XAG_IDLE;
                end
            end
            XAG_FLASH: begin
                done_d = 1'b1;
                state_d = XAG_IDLE;
            end
            default: state_d = XAG_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= XAG_IDLE;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            write_q <= 1'b0;
            rdata_q <= 8'h00;
            done_q <= 1'b0;
            offReq_q <= 1'b0;
            flReq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            write_q <= write_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
            offReq_q <= offReq_d;
            flReq_q <= flReq_d;
        end
    end

    assign dataPointerHigh = ptrHigh_q;
    assign dataPointerLow = ptrLow_q;
    assign xramPageSelect = page_q;
    assign xmoveDone = done_q;
    // Both targets land in one read register; a RAM or flash write leaves the last byte there, an off-chip write loads the returned byte.
    assign xmoveRdata = rdata_q;
    assign offchipReq = offReq_q;
    assign offchipWrite = write_q;
    assign offchipAddr = addr_q;
    assign offchipWdata = wdata_q;
    assign flashWriteReq = flReq_q;
    assign flashAddr = addr_q;
    assign flashWdata = wdata_q;

    // Most properties look one edge past their trigger, where the registered outputs
    // already carry the answer.
    a_wide_addr: assert property (@(posedge clk_sys) disable iff (rst)
        xmoveReq && xmoveWide && state_q == XAG_IDLE
        |=> addr_q == $past({ptrHigh_q, ptrLow_q}))
        else $error("Wide address not taken from data pointer.");
    a_narrow_addr: assert property (@(posedge clk_sys) disable iff (rst)
        xmoveReq && !xmoveWide && state_q == XAG_IDLE
        |=> addr_q == $past({page_q, indexValue}))
        else $error("Narrow address not page plus index.");
    a_ptr_high_load: assert property (@(posedge clk_sys) disable iff (rst)
        dataPointerHighWe |=> dataPointerHigh == $past(cpuWdata))
        else $error("High pointer byte not loaded.");
    a_ptr_low_load: assert property (@(posedge clk_sys) disable iff (rst)
        dataPointerLowWe |=> dataPointerLow == $past(cpuWdata))
        else $error("Low pointer byte not loaded.");
    a_page_load: assert property (@(posedge clk_sys) disable iff (rst)
        pageWe |=> xramPageSelect == $past(cpuWdata))
        else $error("Page byte not loaded.");
    a_ram_done: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == XAG_IDLE && xmoveReq && inRam && !(xmoveWrite && flashWriteEn)
        |=> ##1 xmoveDone && !offchipReq)
        else $error("On-chip access not done in two cycles.");
    a_flash_gate: assert property (@(posedge clk_sys) disable iff (rst)
        flashWriteReq |-> $past(flashWriteEn) && write_q)
        else $error("Flash write without enable.");
    a_flash_done: assert property (@(posedge clk_sys) disable iff (rst)
        flashWriteReq |=> xmoveDone && state_q == XAG_IDLE)
        else $error("Flash write not reported done.");
    a_read_not_flash: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == XAG_IDLE && xmoveReq && !xmoveWrite |=> !flashWriteReq)
        else $error("Read sent to flash.");
    a_no_flash_default: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == XAG_IDLE && xmoveReq && !flashWriteEn |=> !flashWriteReq)
        else $error("Flash used while redirect is off.");
    a_done_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        xmoveDone |=> !xmoveDone)
        else $error("Done stretched beyond one cycle.");
    a_off_route: assert property (@(posedge clk_sys) disable iff (rst)
        offchipReq |-> $past(!inRam || offchipRamOnly) && HasOffchip)
        else $error("Off-chip request for on-chip address.");
    a_off_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        offchipReq |=> !offchipReq)
        else $error("Off-chip request stretched.");
    a_off_hold: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == XAG_OFFCHIP && !offchipDone |=> $stable(offchipAddr) && !xmoveDone)
        else $error("Off-chip access changed while waiting.");
    a_off_done: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == XAG_OFFCHIP && offchipDone |=> xmoveDone && state_q == XAG_IDLE)
        else $error("Off-chip completion not reported.");
    a_off_rdata: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == XAG_OFFCHIP && offchipDone |=> xmoveRdata == $past(offchipRdata))
        else $error("Off-chip read byte not returned.");
    a_busy_hold: assert property (@(posedge clk_sys) disable iff (rst)
        state_q != XAG_IDLE && xmoveReq |=> $stable(offchipAddr))
        else $error("Request taken while an access was in flight.");
endmodule : external_data_space_address_generation

// ==== testbench/xag_offchip_model.sv ====
`timescale 1ns/100ps
// Off-chip data memory; slow stretches each answer so the wait path is exercised.
module xag_offchip_model import xag_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    input wire logic offchipReq,
    input wire logic offchipWrite,
    input wire logic [15:0] offchipAddr,
    input wire logic [7:0] offchipWdata,
    output logic offchipDone,
    output logic [7:0] offchipRdata
);
    logic [7:0] mem [logic [15:0]];
    initial begin
        offchipDone = 1'b0;
        offchipRdata = 8'h00;
        forever begin
            @(posedge clk_sys);
            if (!rst && offchipReq === 1'b1) begin
                repeat (slow ? 4 : 1) @(posedge clk_sys);
                #1;
                if (offchipWrite) mem[offchipAddr] = offchipWdata;
                offchipRdata = mem.exists(offchipAddr) ? mem[offchipAddr] : 8'h5a;
                offchipDone = 1'b1;
                @(posedge clk_sys);
                #1;
                offchipDone = 1'b0;
                // Released data is scrambled so a late sample cannot pass.
                offchipRdata = ~offchipRdata;
            end
        end
    end
endmodule : xag_offchip_model

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb import xag_pkg::*;;
    logic clk_sys, rst, dataPointerHighWe, dataPointerLowWe, pageWe, xmoveReq, xmoveWrite;
    logic xmoveWide;
    logic flashWriteEn, offchipRamOnly, xmoveDone, offchipReq, offchipWrite, offchipDone;
    logic flashWriteReq, slow, sawF, sawO;
    logic [7:0] cpuWdata, indexValue, xmoveWdata, dataPointerHigh, dataPointerLow, rd;
    logic [7:0] xramPageSelect, xmoveRdata, offchipWdata, offchipRdata, flashWdata;
    logic [15:0] offchipAddr, flashAddr;
    int errTotal = 0;
    int checkCount = 0;
    external_data_space_address_generation external_data_space_address_generation_i (.*);
    xag_offchip_model xag_offchip_model_i (.*);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checkCount++;
        if (g !== e) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic ld(input int s, input logic [7:0] v);
        cpuWdata = v;
        {dataPointerHighWe, dataPointerLowWe, pageWe} = 3'b100 >> s;
        @(posedge clk_sys);
        #1 {dataPointerHighWe, dataPointerLowWe, pageWe} = 3'b000;
        // An idle edge keeps the next strobe from landing in the same time step.
        @(posedge clk_sys);
        #1;
    endtask : ld
    task automatic acc(input logic w, input logic wd, input logic [7:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        {sawF, sawO} = 2'b00;
        {xmoveWrite, xmoveWide, indexValue, xmoveWdata, xmoveReq} = {w, wd, ix, d, 1'b1};
        do begin
            @(posedge clk_sys);
            #1 xmoveReq = 1'b0;
            sawF |= flashWriteReq === 1'b1;
            sawO |= offchipReq === 1'b1;
            n++;
        end while (xmoveDone !== 1'b1 && n < 40);
        rd = xmoveRdata;
        chk("done", 16'h1, 16'(n < 40));
    endtask : acc
    task automatic tRegs();
        chk("reset ptr", 16'h0, {dataPointerHigh, dataPointerLow});
        ld(0, 8'h12);
        ld(1, 8'h34);
        ld(2, 8'h56);
        chk("ptr", 16'h1234, {dataPointerHigh, dataPointerLow});
        chk("page", 16'h56, 16'(xramPageSelect));
    endtask : tRegs
    task automatic tRam();
        ld(0, 8'h03);
        ld(1, 8'hff);
        acc(1'b1, 1'b1, 8'h00, 8'ha5);
        ld(2, 8'h03);
        acc(1'b0, 1'b0, 8'hff, 8'h00);
        chk("ram rd", 16'ha5, 16'(rd));
        chk("ram local", 16'h0, 16'(sawO));
    endtask : tRam
    task automatic tOff();
        slow = 1'b1;
        ld(0, 8'h12);
        ld(1, 8'h34);
        acc(1'b1, 1'b1, 8'h00, 8'hc3);
        chk("off addr", 16'h1234, offchipAddr);
        chk("off wr", 16'h1c3, {7'h0, sawO, offchipWdata});
        ld(2, 8'h12);
        acc(1'b0, 1'b0, 8'h34, 8'h00);
        chk("off rd", 16'hc3, 16'(rd));
        ld(2, 8'h00);
        offchipRamOnly = 1'b1;
        acc(1'b0, 1'b0, 8'h34, 8'h00);
        chk("off only", 16'h1, 16'(sawO));
        chk("off only rd", 16'h5a, 16'(rd));
        offchipRamOnly = 1'b0;
    endtask : tOff
    task automatic tFlash();
        ld(0, 8'h00);
        ld(1, 8'h10);
        acc(1'b1, 1'b1, 8'h00, 8'h11);
        flashWriteEn = 1'b1;
        acc(1'b1, 1'b1, 8'h00, 8'h77);
        chk("flash", 16'h177, {7'h0, sawF, flashWdata});
        chk("flash addr", 16'h0010, flashAddr);
        acc(1'b0, 1'b1, 8'h00, 8'h00);
        chk("read not flash", 16'h011, {7'h0, sawF, rd});
        flashWriteEn = 1'b0;
        acc(1'b0, 1'b1, 8'h00, 8'h00);
        chk("ram kept", 16'h11, 16'(rd));
    endtask : tFlash
    task automatic wrapUp();
        if (errTotal == 0 && checkCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrapUp
    initial begin
        repeat (3000) @(posedge clk_sys);
        errTotal++;
        wrapUp();
    end
    initial begin
        {rst, slow, dataPointerHighWe, dataPointerLowWe, pageWe, xmoveReq, xmoveWrite} = 7'h40;
        {xmoveWide, flashWriteEn, offchipRamOnly, cpuWdata, indexValue, xmoveWdata} = 27'h0;
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'b0;
        tRegs();
        tRam();
        tOff();
        tFlash();
        wrapUp();
    end
endmodule : tb
